// ===== cbu_pkg.sv
// constants and types shared by the conditional branch unit
package cbu_pkg;
    localparam int PC_W = 16;
    localparam int OFF_W = 7;
    localparam int SR_W = 8;
    localparam int SEL_W = 3;
    localparam int OP_W = 3;
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
    localparam logic [PC_W-1:0] PC_RST = 16'h0000;
    localparam int SKIP_CYCLES = 1;
    localparam int TAKEN_CYCLES = 2;

    typedef enum logic [OP_W-1:0] {
        CBU_OP_STATUS_BIT_CLEAR = 3'h0,
        CBU_OP_EQUAL = 3'h1,
        CBU_OP_NOT_EQUAL = 3'h2,
        CBU_OP_CARRY_SET = 3'h3,
        CBU_OP_CARRY_CLEAR = 3'h4,
        CBU_OP_SAME_OR_HIGHER = 3'h5
    } cbu_op_t;

    typedef enum logic [1:0] {
        CBU_ST_IDLE = 2'h1,
        CBU_ST_FLUSH = 2'h2
    } cbu_state_t;
endpackage : cbu_pkg

// ===== cbu_eval_if.sv
// carrier between the branch sequencer and the condition evaluator
`timescale 1ns/100ps
`default_nettype none
interface cbu_eval_if;
    logic [cbu_pkg::OP_W-1:0] op;
    logic [cbu_pkg::SEL_W-1:0] sel;
    logic [cbu_pkg::SR_W-1:0] status;
    logic [cbu_pkg::OFF_W-1:0] offset;
    logic [cbu_pkg::PC_W-1:0] pc;
    logic cond;
    logic [cbu_pkg::PC_W-1:0] target;
    logic [cbu_pkg::PC_W-1:0] next_pc;

    modport ask (
        output op,
        output sel,
        output status,
        output offset,
        output pc,
        input cond,
        input target,
        input next_pc
    );

    modport eval (
        input op,
        input sel,
        input status,
        input offset,
        input pc,
        output cond,
        output target,
        output next_pc
    );
endinterface : cbu_eval_if
`default_nettype wire

// ===== cbu_cond.sv
// condition evaluator and branch target adder
`timescale 1ns/100ps
`default_nettype none
module cbu_cond (
    cbu_eval_if.eval ev
);
    function automatic logic [cbu_pkg::PC_W-1:0] sext_off(
        input logic [cbu_pkg::OFF_W-1:0] k
    );
        sext_off = {{(cbu_pkg::PC_W-cbu_pkg::OFF_W){k[cbu_pkg::OFF_W-1]}}, k};
    endfunction : sext_off

    // wraps modulo the program counter width, as the core does
    function automatic logic [cbu_pkg::PC_W-1:0] pc_add(
        input logic [cbu_pkg::PC_W-1:0] base,
        input logic [cbu_pkg::PC_W-1:0] delta
    );
        pc_add = base + delta;
    endfunction : pc_add

    wire logic flag_z;
    wire logic flag_c;
    wire logic sel_bit;
    wire logic op_bit_clear;
    wire logic op_equal;
    wire logic op_not_equal;
    wire logic op_carry_set;
    wire logic op_carry_clear;

    assign flag_z = ev.status[cbu_pkg::FLAG_Z];
    assign flag_c = ev.status[cbu_pkg::FLAG_C];
    assign sel_bit = ev.status[ev.sel];
    assign op_bit_clear = ev.op == cbu_pkg::CBU_OP_STATUS_BIT_CLEAR;
    assign op_equal = ev.op == cbu_pkg::CBU_OP_EQUAL;
    assign op_not_equal = ev.op == cbu_pkg::CBU_OP_NOT_EQUAL;
    assign op_carry_set = ev.op == cbu_pkg::CBU_OP_CARRY_SET;
    // same-or-higher is the carry-clear test under another name
    assign op_carry_clear = (ev.op == cbu_pkg::CBU_OP_CARRY_CLEAR)
        || (ev.op == cbu_pkg::CBU_OP_SAME_OR_HIGHER);

    // unlisted codes never branch
    assign ev.cond = (op_bit_clear && !sel_bit)
        || (op_equal && flag_z)
        || (op_not_equal && !flag_z)
        || (op_carry_set && flag_c)
        || (op_carry_clear && !flag_c);

    assign ev.target = pc_add(pc_add(ev.pc, sext_off(ev.offset)),
        cbu_pkg::PC_STEP);
    assign ev.next_pc = pc_add(ev.pc, cbu_pkg::PC_STEP);
endmodule : cbu_cond
`default_nettype wire

// ===== cbu_top.sv
// conditional branch unit: sequencing, program counter hand-off, checks
`timescale 1ns/100ps
`default_nettype none
module cbu_top (
    input wire logic I_REF_CLK,
    input wire logic I_RESET_N,
    input wire logic I_ISSUE,
    input wire logic [cbu_pkg::OP_W-1:0] I_OP,
    input wire logic [cbu_pkg::SEL_W-1:0] I_BIT_SEL,
    input wire logic [cbu_pkg::OFF_W-1:0] I_OFFSET,
    input wire logic [cbu_pkg::SR_W-1:0] I_STATUS,
    input wire logic [cbu_pkg::PC_W-1:0] I_PC,
    output logic O_READY,
    output logic O_STALL,
    output logic O_PC_LOAD,
    output logic [cbu_pkg::PC_W-1:0] O_PC_NEXT,
    output logic O_TAKEN,
    output logic O_DONE,
    output logic O_STATUS_WE
);
    cbu_eval_if ev_bus ();

    cbu_pkg::cbu_state_t state_q;
    cbu_pkg::cbu_state_t state_d;
    logic [cbu_pkg::PC_W-1:0] pc_next_q;
    logic [cbu_pkg::PC_W-1:0] pc_next_d;
    logic pc_load_q;
    logic pc_load_d;
    logic taken_q;
    logic taken_d;
    logic done_q;
    logic done_d;

    wire logic idle;
    wire logic flushing;
    wire logic accept;
    wire logic take;

    assign ev_bus.op = I_OP;
    assign ev_bus.sel = I_BIT_SEL;
    assign ev_bus.status = I_STATUS;
    assign ev_bus.offset = I_OFFSET;
    assign ev_bus.pc = I_PC;

    cbu_cond u_cond (
        .ev(ev_bus)
    );

    assign idle = state_q == cbu_pkg::CBU_ST_IDLE;
    assign flushing = state_q == cbu_pkg::CBU_ST_FLUSH;
    // an issue while flushing is ignored; the decoder sees O_READY low
    assign accept = I_ISSUE && idle;
    assign take = accept && ev_bus.cond;

    // taken branch spends one extra cycle so fetch can refill
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            cbu_pkg::CBU_ST_IDLE: begin
                if (take) begin
                    state_d = cbu_pkg::CBU_ST_FLUSH;
                end
            end
            cbu_pkg::CBU_ST_FLUSH: begin
                state_d = cbu_pkg::CBU_ST_IDLE;
            end
            default: begin
                state_d = cbu_pkg::CBU_ST_IDLE;
            end
        endcase
    end

    assign pc_next_d = accept ? (take ? ev_bus.target : ev_bus.next_pc)
        : pc_next_q;
    assign pc_load_d = take;
    assign taken_d = accept ? ev_bus.cond : (flushing && taken_q);
    assign done_d = (accept && !ev_bus.cond) || flushing;

    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            state_q <= cbu_pkg::CBU_ST_IDLE;
            pc_next_q <= cbu_pkg::PC_RST;
            pc_load_q <= 1'h0;
            taken_q <= 1'h0;
            done_q <= 1'h0;
        end else begin
            state_q <= state_d;
            pc_next_q <= pc_next_d;
            pc_load_q <= pc_load_d;
            taken_q <= taken_d;
            done_q <= done_d;
        end
    end

    assign O_READY = idle;
    assign O_STALL = flushing;
    assign O_PC_LOAD = pc_load_q;
    assign O_PC_NEXT = pc_next_q;
    assign O_TAKEN = taken_q;
    assign O_DONE = done_q;
    // branches never touch the flags, so the write strobe stays low
    assign O_STATUS_WE = 1'h0;

    // reference values the checks compare against
    wire logic chk_sel_bit;
    wire logic chk_z;
    wire logic chk_c;
    wire logic [cbu_pkg::PC_W-1:0] chk_target;
    wire logic [cbu_pkg::PC_W-1:0] chk_sext;
    wire logic chk_neg;

    assign chk_sel_bit = I_STATUS[I_BIT_SEL];
    assign chk_z = I_STATUS[cbu_pkg::FLAG_Z];
    assign chk_c = I_STATUS[cbu_pkg::FLAG_C];
    // sign of k, taken from the top bit of the offset field
    assign chk_neg = I_OFFSET[cbu_pkg::OFF_W-1];
    assign chk_sext = {{(cbu_pkg::PC_W-cbu_pkg::OFF_W){chk_neg}},
        I_OFFSET};
    assign chk_target = I_PC + chk_sext + cbu_pkg::PC_STEP;

    AST_BIT_CLEAR: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RESET_N)
        accept && (I_OP == cbu_pkg::CBU_OP_STATUS_BIT_CLEAR)
        |=> O_PC_LOAD == !$past(chk_sel_bit))
        else $error("status-bit-clear branch decision wrong");

    AST_EQUAL: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RESET_N)
        accept && (I_OP == cbu_pkg::CBU_OP_EQUAL)
        |=> O_PC_LOAD == $past(chk_z))
        else $error("equal branch decision wrong");

    AST_NOT_EQUAL: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RESET_N)
        accept && (I_OP == cbu_pkg::CBU_OP_NOT_EQUAL)
        |=> O_PC_LOAD == !$past(chk_z))
        else $error("not-equal branch decision wrong");

    AST_CARRY_SET: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RESET_N)
        accept && (I_OP == cbu_pkg::CBU_OP_CARRY_SET)
        |=> O_PC_LOAD == $past(chk_c))
        else $error("carry-set branch decision wrong");

    AST_CARRY_CLEAR: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RESET_N)
        accept && ((I_OP == cbu_pkg::CBU_OP_CARRY_CLEAR)
        || (I_OP == cbu_pkg::CBU_OP_SAME_OR_HIGHER))
        |=> O_PC_LOAD == !$past(chk_c))
        else $error("carry-clear branch decision wrong");

    AST_NO_FLAG_WRITE: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RESET_N)
        (O_DONE || O_PC_LOAD || O_STALL) |-> !O_STATUS_WE)
        else $error("branch wrote the status flags");

    AST_TAKEN_TWO: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RESET_N)
        take |=> (O_PC_LOAD && O_STALL && !O_DONE && !O_READY)
        ##1 (O_DONE && O_TAKEN && O_READY && !O_PC_LOAD))
        else $error("taken branch did not last two cycles");

    AST_SKIP_ONE: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RESET_N)
        accept && !ev_bus.cond
        |=> O_DONE && !O_TAKEN && !O_PC_LOAD && O_READY)
        else $error("untaken branch did not finish in one cycle");

    AST_TARGET: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RESET_N)
        take |=> O_PC_NEXT == $past(chk_target))
        else $error("branch target is not pc plus signed k plus one");

    AST_SEQ_PC: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RESET_N)
        accept && !ev_bus.cond
        |=> O_PC_NEXT == ($past(I_PC) + cbu_pkg::PC_STEP))
        else $error("untaken branch next pc is not pc plus one");

    AST_PC_HOLD: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RESET_N)
        !accept |=> $stable(O_PC_NEXT))
        else $error("next pc changed without an accepted branch");

    // an issue seen in the flush cycle must leave no trace
    AST_FLUSH_REFUSE: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RESET_N)
        I_ISSUE && flushing |=> !O_PC_LOAD && $stable(O_PC_NEXT))
        else $error("issue during the flush cycle was not ignored");

    AST_LOAD_PULSE: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RESET_N)
        O_PC_LOAD |=> !O_PC_LOAD && !O_STALL)
        else $error("pc load strobe lasted more than one cycle");

    AST_TAKEN_END: assert property (@(posedge I_REF_CLK)
        disable iff (!I_RESET_N)
        O_DONE && O_TAKEN |=> !O_TAKEN || O_PC_LOAD)
        else $error("taken flag outlived its branch");

    COV_TAKEN: cover property (@(posedge I_REF_CLK)
        disable iff (!I_RESET_N)
        take ##1 O_STALL ##1 O_DONE);

    COV_NOT_TAKEN: cover property (@(posedge I_REF_CLK)
        disable iff (!I_RESET_N)
        accept && !ev_bus.cond ##1 O_DONE);

    COV_BACK_TO_BACK: cover property (@(posedge I_REF_CLK)
        disable iff (!I_RESET_N)
        (accept && !ev_bus.cond) ##1 take);

    COV_BACKWARD: cover property (@(posedge I_REF_CLK)
        disable iff (!I_RESET_N)
        take && chk_neg);
endmodule : cbu_top
`default_nettype wire

// ===== cbu_pc_model.sv
// behavioural program counter of the fetch side
`timescale 1ns/100ps
`default_nettype none
module cbu_pc_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_load,
    input wire logic i_done,
    input wire logic [15:0] i_next,
    output logic [15:0] o_pc
);
    // follows either strobe: pc+1 only ever arrives with done
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) o_pc <= 16'h0000;
        else if (i_load || i_done) o_pc <= i_next;
    end
endmodule : cbu_pc_model
`default_nettype wire

// ===== test_conditional_branch_unit.sv
// self-checking bench of the conditional branch unit
`timescale 1ns/100ps
`default_nettype none
module test_conditional_branch_unit;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic iss = 1'h0;
    logic [2:0] op = 3'h0;
    logic [2:0] sel = 3'h0;
    logic [6:0] k = 7'h00;
    logic [7:0] st = 8'h00;
    logic [15:0] pc = 16'h0000;
    logic rdy, stl, ld, tk, dn, swe;
    logic [15:0] nx, mpc;
    int n_mismatch = 0;
    int check_count = 0;

    cbu_top cbu_top_inst (.I_REF_CLK(clk), .I_RESET_N(rst_n), .I_ISSUE(iss),
        .I_OP(op), .I_BIT_SEL(sel), .I_OFFSET(k), .I_STATUS(st), .I_PC(pc),
        .O_READY(rdy), .O_STALL(stl), .O_PC_LOAD(ld), .O_PC_NEXT(nx),
        .O_TAKEN(tk), .O_DONE(dn), .O_STATUS_WE(swe));
    cbu_pc_model cbu_pc_model_inst (.i_clk(clk), .i_rst_n(rst_n),
        .i_load(ld), .i_done(dn), .i_next(nx), .o_pc(mpc));

    initial forever #20 clk = ~clk;

    // flag order: ready, stall, load, taken, done, status write
    function automatic logic [15:0] fl();
        return {10'h000, rdy, stl, ld, tk, dn, swe};
    endfunction : fl

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask : cmp

    // one branch from issue to completion, pc hand-off checked at the end
    task automatic exec(input logic [2:0] o, input logic [2:0] s,
        input logic [6:0] kk, input logic [7:0] sr, input logic [15:0] p,
        input logic t);
        logic [15:0] tgt;
        tgt = t ? p + {{9{kk[6]}}, kk} + 16'h0001 : p + 16'h0001;
        @(posedge clk);
        {iss, op, sel, k, st, pc} <= {1'h1, o, s, kk, sr, p};
        @(posedge clk);
        iss <= 1'h0;
        #1;
        cmp(fl(), {10'h000, !t, t, t, t, !t, 1'h0});
        cmp(nx, tgt);
        if (t) begin
            @(posedge clk);
            #1;
            cmp(fl(), 16'h0026);
        end
        @(posedge clk);
        #1;
        cmp(mpc, tgt);
        cmp(fl(), 16'h0020);
    endtask : exec

    task automatic t_bit_clear;
        for (int i = 0; i < 8; i++) begin
            exec(3'h0, i[2:0], 7'h05, ~(8'h01 << i), 16'h0100, 1'h1);
            exec(3'h0, i[2:0], 7'h05, 8'h01 << i, 16'h0100, 1'h0);
        end
    endtask : t_bit_clear

    task automatic t_flags;
        exec(3'h1, 3'h0, 7'h10, 8'h02, 16'h0200, 1'h1);
        exec(3'h1, 3'h0, 7'h10, 8'hfd, 16'h0200, 1'h0);
        exec(3'h2, 3'h0, 7'h10, 8'hfd, 16'h0200, 1'h1);
        exec(3'h2, 3'h0, 7'h10, 8'h02, 16'h0200, 1'h0);
        // index points at a clear bit: must not matter here
        exec(3'h3, 3'h7, 7'h10, 8'h01, 16'h0200, 1'h1);
        exec(3'h3, 3'h0, 7'h10, 8'hfe, 16'h0200, 1'h0);
        for (int o = 4; o < 6; o++) begin
            exec(o[2:0], 3'h0, 7'h10, 8'hfe, 16'h0200, 1'h1);
            exec(o[2:0], 3'h0, 7'h10, 8'h01, 16'h0200, 1'h0);
        end
        // unlisted codes never branch, whatever the flags hold
        exec(3'h6, 3'h0, 7'h10, 8'h00, 16'h0200, 1'h0);
        exec(3'h7, 3'h0, 7'h10, 8'hff, 16'h0200, 1'h0);
    endtask : t_flags

    task automatic t_offset;
        exec(3'h1, 3'h0, 7'h40, 8'h02, 16'h0010, 1'h1);
        exec(3'h1, 3'h0, 7'h3f, 8'h02, 16'hffff, 1'h1);
        exec(3'h1, 3'h0, 7'h7f, 8'h02, 16'h0000, 1'h1);
    endtask : t_offset

    // issue held through the flush cycle must be ignored, then accepted
    task automatic t_flush;
        @(posedge clk);
        {iss, op, sel, k, st, pc} <= {1'h1, 3'h1, 3'h0, 7'h04, 8'h02, 16'h0300};
        @(posedge clk);
        {op, st, pc} <= {3'h3, 8'h00, 16'h0400};
        #1;
        cmp(fl(), 16'h001c);
        @(posedge clk);
        #1;
        cmp(fl(), 16'h0026);
        cmp(nx, 16'h0305);
        @(posedge clk);
        iss <= 1'h0;
        #1;
        cmp(fl(), 16'h0022);
        cmp(nx, 16'h0401);
    endtask : t_flush

    // skip then taken on consecutive edges, no idle cycle between them
    task automatic t_back_to_back;
        @(posedge clk);
        {iss, op, sel, k, st, pc} <= {1'h1, 3'h2, 3'h0, 7'h08, 8'h02, 16'h0700};
        @(posedge clk);
        {op, st, pc} <= {3'h4, 8'h00, 16'h0701};
        #1;
        cmp(fl(), 16'h0022);
        cmp(nx, 16'h0701);
        @(posedge clk);
        iss <= 1'h0;
        #1;
        cmp(fl(), 16'h001c);
        cmp(nx, 16'h070a);
        @(posedge clk);
        #1;
        cmp(fl(), 16'h0026);
        cmp(mpc, 16'h070a);
    endtask : t_back_to_back

    // reset in the flush cycle drops the branch and restores idle outputs
    task automatic t_reset;
        @(posedge clk);
        {iss, op, sel, k, st, pc} <= {1'h1, 3'h1, 3'h0, 7'h04, 8'h02, 16'h0500};
        @(posedge clk);
        {iss, rst_n} <= 2'h0;
        #1;
        cmp(fl(), 16'h0020);
        cmp(nx, 16'h0000);
        cmp(mpc, 16'h0000);
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        #1;
        cmp(fl(), 16'h0020);
        exec(3'h2, 3'h0, 7'h02, 8'h00, 16'h0500, 1'h1);
    endtask : t_reset

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        #1;
        cmp(fl(), 16'h0020);
        cmp(nx, 16'h0000);
        t_bit_clear();
        t_flags();
        t_offset();
        t_flush();
        t_back_to_back();
        t_reset();
        final_report();
    end

    // some 40 branches of at most four cycles; generous margin
    initial begin
        #100us;
        n_mismatch++;
        final_report();
    end
endmodule : test_conditional_branch_unit
`default_nettype wire
